// >>> eag_core.sv
`timescale 1ns/1ps
// Contract
// (RULE_01) Register direct selects only data register halves, 16-bit data/address regs or data pairs.
// (RULE_02) Address-register indirect gives the address register itself, no offset.
// (RULE_03) Address-register relative adds an unsigned 8/16/24-bit displacement.
// (RULE_04) Address-register relative overflow drops carries and wraps to zero.
// (RULE_05) Static-base relative adds the zero-extended displacement, wrapping to zero.
// (RULE_06) Static-base 8-bit reach is 0..255 and 16-bit reach is 0..65535.
// (RULE_07) Frame-base relative adds the sign-extended 8 or 16-bit displacement.
// (RULE_08) Frame-base results outside the space wrap to the bottom or top.
// (RULE_09) Stack-pointer relative is only for move and adds a signed 8-bit displacement.
// (RULE_10) Absolute indirect reads a 4-byte pointer at the absolute address and uses it.
// (RULE_11) Two-stage indirect fetches a 4-byte pointer at the address register value.
// (RULE_12) Relative indirect fetches a 4-byte pointer at address register plus displacement.
// (RULE_13) Short jump adds an unsigned displacement giving PC+2..PC+9, plain jump only.
// (RULE_14) Byte/word jumps and calls add a sign-extended displacement.
// (RULE_15) Program-counter relative targets wrap at the ends of the space.
// (RULE_16) Special addressing can select control registers as well as memory.
// (RULE_17) A fetched pointer contributes only its low address-width bits.
module eag_core
    import eag_pkg::*;
(
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              reset,
    // request from decoder
    input  wire logic              req_valid,
    input  wire eag_req_t          req,
    input  wire eag_regs_t         regs,
    // pointer fetch, one byte per beat
    output logic                   mem_rd,
    output logic [ADDR_W-1:0]      mem_addr,
    input  wire logic              mem_ack,
    input  wire logic [7:0]        mem_rdata,
    // result
    output logic                   busy,
    output logic                   res_valid,
    output eag_res_t               res
);
    localparam logic [ADDR_W-1:0] SHORT_BASE = 24'h000002;
    localparam logic [2:0]        LAST_BYTE  = 3'(PTR_BYTES - 1);

    typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_WAIT} eag_st_t;

    eag_st_t             st_r;
    logic [2:0]          byte_r;
    logic [31:0]         ptr_r;
    logic [ADDR_W-1:0]   ptr_base_r;

    // all sums are cut to the address width, which is the wrap
    function automatic logic [ADDR_W-1:0] wrap_add(input logic [ADDR_W-1:0] a,
                                                   input logic [ADDR_W-1:0] b);
        logic [ADDR_W:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[ADDR_W-1:0];
    endfunction

    function automatic logic [ADDR_W-1:0] dsp_ext(input logic [ADDR_W-1:0] d,
                                                  input eag_dsp_t sz, input logic sgn);
        logic [ADDR_W-1:0] r;
        r = d;
        unique case (sz)
            EAG_DSP_8:  r = {{(ADDR_W-8){sgn & d[7]}}, d[7:0]};
            EAG_DSP_16: r = {{(ADDR_W-16){sgn & d[15]}}, d[15:0]};
            default:    r = d;
        endcase
        return r;
    endfunction

    logic [ADDR_W-1:0] areg, ea, pc_tgt;
    logic              is_ind, is_illegal;
    logic [31:0]       rval;

    always_comb begin
        areg = req.areg_one ? regs.addr_reg_one : regs.addr_reg_zero;
        ea = ADDR_ZERO;
        is_ind = 1'b0;
        is_illegal = 1'b0;
        unique case (req.mode)
            EAG_M_AREG_IND, EAG_M_AREG_IND2: ea = areg;                    // [RULE_02] [RULE_11]
            EAG_M_AREG_REL, EAG_M_AREG_REL_IND:
                ea = wrap_add(areg, dsp_ext(req.dsp, req.dsp_size, 1'b0)); // [RULE_03] [RULE_04] [RULE_12]
            EAG_M_SB_REL, EAG_M_SB_REL_IND: begin
                // 24-bit form does not exist here
                ea = wrap_add(regs.static_base_reg, dsp_ext(req.dsp, req.dsp_size, 1'b0)); // [RULE_05] [RULE_06]
                is_illegal = (req.dsp_size == EAG_DSP_24);
            end
            EAG_M_FB_REL, EAG_M_FB_REL_IND: begin
                ea = wrap_add(regs.frame_base_reg, dsp_ext(req.dsp, req.dsp_size, 1'b1)); // [RULE_07] [RULE_08]
                is_illegal = (req.dsp_size == EAG_DSP_24);
            end
            EAG_M_SP_REL: begin
                ea = wrap_add(regs.stack_ptr_reg, dsp_ext(req.dsp, EAG_DSP_8, 1'b1)); // [RULE_09]
                is_illegal = (req.op != EAG_OP_MOVE);                                 // [RULE_09]
            end
            EAG_M_ABS, EAG_M_ABS_IND: ea = req.dsp;                        // [RULE_10]
            default: ea = ADDR_ZERO;
        endcase
        if (req.mode inside {EAG_M_ABS_IND, EAG_M_AREG_IND2, EAG_M_AREG_REL_IND,
                             EAG_M_SB_REL_IND, EAG_M_FB_REL_IND})
            is_ind = 1'b1;
    end

    // program-counter relative target
    always_comb begin
        pc_tgt = regs.pc;
        unique case (req.jlen)
            EAG_J_SHORT: pc_tgt = wrap_add(wrap_add(regs.pc, SHORT_BASE),
                                           {{(ADDR_W-3){1'b0}}, req.dsp[2:0]}); // [RULE_13] [RULE_15]
            EAG_J_BYTE:  pc_tgt = wrap_add(regs.pc, dsp_ext(req.dsp, EAG_DSP_8, 1'b1));  // [RULE_14] [RULE_15]
            default:     pc_tgt = wrap_add(regs.pc, dsp_ext(req.dsp, EAG_DSP_16, 1'b1)); // [RULE_14] [RULE_15]
        endcase
    end

    // register direct operand value
    always_comb begin
        rval = WORD_ZERO;
        unique case (req.reg_sel)                                          // [RULE_01]
            EAG_R_DATA_REG0_LOW:  rval = {24'h000000, regs.data_reg0[7:0]};
            EAG_R_DATA_REG0_HIGH: rval = {24'h000000, regs.data_reg0[15:8]};
            EAG_R_DATA_REG1_LOW:  rval = {24'h000000, regs.data_reg1[7:0]};
            EAG_R_DATA_REG1_HIGH: rval = {24'h000000, regs.data_reg1[15:8]};
            EAG_R_DATA0:          rval = {16'h0000, regs.data_reg0};
            EAG_R_DATA1:          rval = {16'h0000, regs.data_reg1};
            EAG_R_DATA2:          rval = {16'h0000, regs.data_reg2};
            EAG_R_DATA3:          rval = {16'h0000, regs.data_reg3};
            EAG_R_ADDR_REG_ZERO:  rval = {16'h0000, regs.addr_reg_zero[15:0]};
            EAG_R_ADDR_REG_ONE:   rval = {16'h0000, regs.addr_reg_one[15:0]};
            EAG_R_DATA_PAIR_LOW:  rval = {regs.data_reg2, regs.data_reg0};
            EAG_R_DATA_PAIR_HIGH: rval = {regs.data_reg3, regs.data_reg1};
            default:              rval = WORD_ZERO;
        endcase
    end

    // sequencer: direct modes answer next cycle, legal indirect ones fetch 4 bytes
    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_r       <= ST_IDLE;
            byte_r     <= 3'h0;
            ptr_r      <= 32'h00000000;
            ptr_base_r <= ADDR_ZERO;
            mem_rd     <= 1'b0;
            mem_addr   <= ADDR_ZERO;
            busy       <= 1'b0;
            res_valid  <= 1'b0;
            res        <= '0;
        end else begin
            res_valid <= 1'b0;
            unique case (st_r)
                ST_IDLE: if (req_valid) begin
                    if (is_ind && !is_illegal) begin
                        st_r       <= ST_FETCH;
                        ptr_base_r <= ea;
                        byte_r     <= 3'h0;
                        mem_rd     <= 1'b1;
                        mem_addr   <= ea;                              // [RULE_10] [RULE_11] [RULE_12]
                        busy       <= 1'b1;
                    end else begin
                        res_valid    <= 1'b1;
                        res.illegal  <= is_illegal ||
                            (req.mode == EAG_M_PC_REL && req.jlen == EAG_J_SHORT &&
                             req.op != EAG_OP_JUMP) ||                  // [RULE_13]
                            (req.mode == EAG_M_PC_REL && req.op != EAG_OP_JUMP &&
                             req.op != EAG_OP_CALL);                    // [RULE_14]
                        res.reg_val  <= rval;
                        res.creg_sel <= req.creg_sel;
                        res.kind     <= (req.mode == EAG_M_REG_DIRECT) ? EAG_K_REG :
                                        (req.mode == EAG_M_CREG_DIRECT) ? EAG_K_CREG :
                                        EAG_K_MEM;                      // [RULE_01] [RULE_16]
                        res.addr     <= (req.mode == EAG_M_PC_REL) ? pc_tgt : ea;
                    end
                end
                ST_FETCH: if (mem_ack) begin
                    // little-endian pointer assembly
                    ptr_r[byte_r*8 +: 8] <= mem_rdata;
                    if (byte_r == LAST_BYTE) begin
                        st_r   <= ST_WAIT;
                        mem_rd <= 1'b0;
                    end else begin
                        byte_r   <= byte_r + 3'h1;
                        mem_addr <= wrap_add(ptr_base_r, {21'h000000, byte_r + 3'h1});
                    end
                end
                ST_WAIT: begin
                    st_r         <= ST_IDLE;
                    busy         <= 1'b0;
                    res_valid    <= 1'b1;
                    res.kind     <= EAG_K_MEM;
                    res.illegal  <= 1'b0;
                    res.reg_val  <= ptr_r;
                    res.addr     <= ptr_r[ADDR_W-1:0];                  // [RULE_17]
                end
                default: st_r <= ST_IDLE;
            endcase
        end
    end
endmodule

// >>> eag_pkg.sv
package eag_pkg;
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int PTR_BYTES = 4;
    localparam int CREG_SEL_W = 4;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 24'h000000;
    localparam logic [31:0] WORD_ZERO = 32'h00000000;

    typedef enum logic [3:0] {
        EAG_M_REG_DIRECT,
        EAG_M_AREG_IND,
        EAG_M_AREG_REL,
        EAG_M_SB_REL,
        EAG_M_FB_REL,
        EAG_M_SP_REL,
        EAG_M_ABS,
        EAG_M_ABS_IND,
        EAG_M_AREG_IND2,
        EAG_M_AREG_REL_IND,
        EAG_M_SB_REL_IND,
        EAG_M_FB_REL_IND,
        EAG_M_PC_REL,
        EAG_M_CREG_DIRECT
    } eag_mode_t;

    // register direct selectors
    typedef enum logic [3:0] {
        EAG_R_DATA_REG0_LOW, EAG_R_DATA_REG0_HIGH, EAG_R_DATA_REG1_LOW, EAG_R_DATA_REG1_HIGH,
        EAG_R_DATA0, EAG_R_DATA1, EAG_R_DATA2, EAG_R_DATA3,
        EAG_R_ADDR_REG_ZERO, EAG_R_ADDR_REG_ONE,
        EAG_R_DATA_PAIR_LOW, EAG_R_DATA_PAIR_HIGH
    } eag_reg_t;

    typedef enum logic [1:0] {EAG_DSP_8, EAG_DSP_16, EAG_DSP_24} eag_dsp_t;
    typedef enum logic [1:0] {EAG_J_SHORT, EAG_J_BYTE, EAG_J_WORD} eag_jlen_t;
    typedef enum logic [1:0] {EAG_OP_OTHER, EAG_OP_MOVE, EAG_OP_JUMP, EAG_OP_CALL} eag_op_t;

    typedef struct packed {
        eag_mode_t               mode;
        eag_op_t                 op;
        eag_reg_t                reg_sel;
        logic                    areg_one;
        eag_dsp_t                dsp_size;
        eag_jlen_t               jlen;
        logic [ADDR_W-1:0]       dsp;
        logic [CREG_SEL_W-1:0]   creg_sel;
    } eag_req_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr_reg_zero;
        logic [ADDR_W-1:0] addr_reg_one;
        logic [ADDR_W-1:0] static_base_reg;
        logic [ADDR_W-1:0] frame_base_reg;
        logic [ADDR_W-1:0] stack_ptr_reg;
        logic [ADDR_W-1:0] pc;
        logic [DATA_W-1:0] data_reg0;
        logic [DATA_W-1:0] data_reg1;
        logic [DATA_W-1:0] data_reg2;
        logic [DATA_W-1:0] data_reg3;
    } eag_regs_t;

    typedef enum logic [1:0] {EAG_K_MEM, EAG_K_REG, EAG_K_CREG} eag_kind_t;

    typedef struct packed {
        eag_kind_t             kind;
        logic [ADDR_W-1:0]     addr;
        logic [31:0]           reg_val;
        logic [CREG_SEL_W-1:0] creg_sel;
        logic                  illegal;
    } eag_res_t;
endpackage

// >>> eag_core_asserts.sv
`timescale 1ns/1ps
module eag_core_asserts
    import eag_pkg::*;
(
    // watched ports
    input wire logic              core_clk,
    input wire logic              reset,
    input wire logic              req_valid,
    input wire eag_req_t          req,
    input wire eag_regs_t         regs,
    input wire logic              mem_rd,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic              mem_ack,
    input wire logic              busy,
    input wire logic              res_valid,
    input wire eag_res_t          res
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    logic take;
    assign take = req_valid && !busy;
    sequence s_take_fetch;
        take && req.mode inside {EAG_M_ABS_IND, EAG_M_AREG_IND2, EAG_M_AREG_REL_IND};
    endsequence
    sequence s_fetch_open;
        mem_rd && busy && !res_valid;
    endsequence
    a_fetch_start: assert property (s_take_fetch |=> s_fetch_open)
        else $error("pointer fetch did not start");
    a_addr_hold: assert property (mem_rd && !mem_ack |=> mem_rd && $stable(mem_addr))
        else $error("fetch address moved before ack");
    a_fetch_close: assert property ($fell(mem_rd) |=> res_valid && !busy)
        else $error("no result after pointer fetch");
    a_areg_ind: assert property (take && req.mode == EAG_M_AREG_IND |=> res.addr ==
        ($past(req.areg_one) ? $past(regs.addr_reg_one) : $past(regs.addr_reg_zero)))
        else $error("register indirect address wrong");
    a_sb_rel: assert property (take && req.mode == EAG_M_SB_REL && req.dsp_size == EAG_DSP_8
        |=> res.addr == $past(regs.static_base_reg) + {16'h0, $past(req.dsp[7:0])})
        else $error("static base address wrong");
    a_fb_rel: assert property (take && req.mode == EAG_M_FB_REL && req.dsp_size == EAG_DSP_16
        |=> res.addr == $past(regs.frame_base_reg) + {{8{$past(req.dsp[15])}}, $past(req.dsp[15:0])})
        else $error("frame base address wrong");
    a_sp_refused: assert property (take && req.mode == EAG_M_SP_REL && req.op != EAG_OP_MOVE
        |=> res_valid && res.illegal)
        else $error("stack relative accepted off move");
    a_short_jump: assert property (take && req.mode == EAG_M_PC_REL && req.jlen == EAG_J_SHORT
        && req.op == EAG_OP_JUMP |=> res.addr == $past(regs.pc) + 24'h2 + {21'h0, $past(req.dsp[2:0])})
        else $error("short jump target wrong");
endmodule

bind eag_core eag_core_asserts eag_core_asserts_i (.core_clk, .reset, .req_valid, .req, .regs,
    .mem_rd, .mem_addr, .mem_ack, .busy, .res_valid, .res);

// >>> effective_address_generator_test.sv
`timescale 1ns/1ps
module effective_address_generator_test
    import eag_pkg::*;
;
    logic              core_clk = 1'b0;
    logic              reset = 1'b1;
    logic              req_valid = 1'b0;
    logic              mem_ack = 1'b0;
    logic [7:0]        mem_rdata = 8'h00;
    eag_req_t          req = '0;
    eag_regs_t         regs = '0;
    logic              mem_rd, busy, res_valid;
    logic [ADDR_W-1:0] mem_addr, ea;
    eag_res_t          res;
    int                failures = 0;
    int                comparisons = 0;

    eag_core eag_core_i (.core_clk(core_clk), .reset(reset), .req_valid(req_valid), .req(req),
        .regs(regs), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .busy(busy), .res_valid(res_valid), .res(res));

    always #5 core_clk = ~core_clk;

    function automatic logic [7:0] mb(logic [ADDR_W-1:0] a);
        return a[7:0] ^ a[23:16] ^ 8'hA5;
    endfunction

    function automatic logic [ADDR_W-1:0] sz(logic [ADDR_W-1:0] d, eag_dsp_t s, logic sg);
        if (s == EAG_DSP_8) begin
            return sg ? {{16{d[7]}}, d[7:0]} : {16'h0, d[7:0]};
        end
        return s == EAG_DSP_16 ? (sg ? {{8{d[15]}}, d[15:0]} : {8'h0, d[15:0]}) : d;
    endfunction

    function automatic logic [ADDR_W-1:0] exp_ea(eag_req_t r, eag_regs_t g);
        logic [ADDR_W-1:0] a;
        a = r.areg_one ? g.addr_reg_one : g.addr_reg_zero;
        case (r.mode)
            EAG_M_AREG_IND, EAG_M_AREG_IND2: return a;
            EAG_M_AREG_REL, EAG_M_AREG_REL_IND: return a + sz(r.dsp, r.dsp_size, 1'b0);
            EAG_M_SB_REL, EAG_M_SB_REL_IND: return g.static_base_reg + sz(r.dsp, r.dsp_size, 1'b0);
            EAG_M_FB_REL, EAG_M_FB_REL_IND: return g.frame_base_reg + sz(r.dsp, r.dsp_size, 1'b1);
            EAG_M_SP_REL: return g.stack_ptr_reg + sz(r.dsp, EAG_DSP_8, 1'b1);
            EAG_M_PC_REL: return r.jlen == EAG_J_SHORT ? g.pc + 24'h2 + {21'h0, r.dsp[2:0]} :
                g.pc + sz(r.dsp, r.jlen == EAG_J_BYTE ? EAG_DSP_8 : EAG_DSP_16, 1'b1);
            default: return r.dsp;
        endcase
    endfunction

    function automatic logic bad(eag_req_t r);
        return (r.mode == EAG_M_SP_REL && r.op != EAG_OP_MOVE) || (r.dsp_size == EAG_DSP_24 &&
            r.mode inside {EAG_M_SB_REL, EAG_M_FB_REL, EAG_M_SB_REL_IND, EAG_M_FB_REL_IND}) ||
            (r.mode == EAG_M_PC_REL && (r.op inside {EAG_OP_OTHER, EAG_OP_MOVE} ||
            (r.jlen == EAG_J_SHORT && r.op != EAG_OP_JUMP)));
    endfunction

    // data pairs put the higher register on top
    function automatic logic [31:0] rv(eag_reg_t s, eag_regs_t g);
        logic [63:0] d;
        d = {g.data_reg3, g.data_reg2, g.data_reg1, g.data_reg0};
        if (s < EAG_R_DATA0) begin
            return 32'(d[s*8 +: 8]);
        end
        if (s < EAG_R_ADDR_REG_ZERO) begin
            return 32'(d[(s-4)*16 +: 16]);
        end
        // address registers act as 16-bit operands here
        if (s < EAG_R_DATA_PAIR_LOW) begin
            return {16'h0000, s == EAG_R_ADDR_REG_ONE ? g.addr_reg_one[15:0] :
                g.addr_reg_zero[15:0]};
        end
        return s == EAG_R_DATA_PAIR_LOW ? {d[47:32], d[15:0]} : {d[63:48], d[31:16]};
    endfunction

    task automatic check(logic [31:0] seen, logic [31:0] want);
        comparisons++;
        if (seen !== want) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    task automatic run(eag_req_t r);
        logic [31:0] p;
        // one idle cycle keeps req_valid from being lowered and raised in one step
        @(posedge core_clk);
        #1;
        ea = exp_ea(r, regs);
        p = {mb(ea + 24'h3), mb(ea + 24'h2), mb(ea + 24'h1), mb(ea)};
        req = r;
        req_valid = 1'b1;
        @(posedge core_clk);
        #1 req_valid = 1'b0;
        // random ack stalls exercise the hold of the fetch address
        for (int i = 0; i < 40 && !res_valid; i++) begin
            if (i == 0 && mem_rd) begin
                check(mem_addr, ea);
            end
            mem_ack = mem_rd & $urandom_range(0, 1);
            mem_rdata = mem_rd ? mb(mem_addr) : ~mem_rdata;
            @(posedge core_clk);
            #1;
        end
        mem_ack = 1'b0;
        check(res_valid, 1);
        check(res.illegal, bad(r));
        if (!bad(r)) begin
            check(res.kind, r.mode == EAG_M_REG_DIRECT ? EAG_K_REG :
                r.mode == EAG_M_CREG_DIRECT ? EAG_K_CREG : EAG_K_MEM);
            if (r.mode == EAG_M_REG_DIRECT) begin
                check(res.reg_val, rv(r.reg_sel, regs));
            end else if (r.mode == EAG_M_CREG_DIRECT) begin
                check({res.kind, res.creg_sel}, {EAG_K_CREG, r.creg_sel});
            end else if (r.mode inside {EAG_M_ABS_IND, EAG_M_AREG_IND2, EAG_M_AREG_REL_IND,
                EAG_M_SB_REL_IND, EAG_M_FB_REL_IND}) begin
                check(res.reg_val, p);
                check(res.addr, p[23:0]);
            end else begin
                check(res.addr, ea);
            end
        end
    endtask

    task automatic corner(eag_mode_t m, eag_op_t o, eag_dsp_t s, eag_jlen_t j,
        logic [23:0] d, logic [23:0] b);
        regs = {{6{b}}, 64'h0123456789ABCDEF};
        run({m, o, EAG_R_DATA0, 1'b0, s, j, d, 4'h3});
    endtask

    task automatic report_and_stop();
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        failures++;
        report_and_stop();
    end

    initial begin
        eag_req_t r;
        void'($urandom(52));
        repeat (16) @(posedge core_clk);
        #1 reset = 1'b0;
        corner(EAG_M_AREG_REL, EAG_OP_MOVE, EAG_DSP_24, EAG_J_BYTE, 24'h000020, 24'hFFFFF0);
        corner(EAG_M_SB_REL, EAG_OP_MOVE, EAG_DSP_16, EAG_J_BYTE, 24'h00FFFF, 24'hFFFF00);
        corner(EAG_M_FB_REL, EAG_OP_MOVE, EAG_DSP_8, EAG_J_BYTE, 24'h000080, 24'h000005);
        corner(EAG_M_PC_REL, EAG_OP_CALL, EAG_DSP_8, EAG_J_BYTE, 24'h000080, 24'h000010);
        corner(EAG_M_PC_REL, EAG_OP_CALL, EAG_DSP_8, EAG_J_SHORT, 24'h000007, 24'h000010);
        corner(EAG_M_AREG_IND2, EAG_OP_MOVE, EAG_DSP_8, EAG_J_BYTE, 24'h0, 24'hFFFFFE);
        for (int n = 0; n < 300; n++) begin
            regs = 208'({$urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom});
            r = {4'($urandom_range(0, 13)), 2'($urandom), 4'($urandom_range(0, 11)), 1'($urandom),
                2'($urandom_range(0, 2)), 2'($urandom_range(0, 2)), 24'($urandom), 4'($urandom)};
            if (r.mode == EAG_M_SP_REL) begin
                r.dsp_size = EAG_DSP_8;
            end
            run(r);
        end
        report_and_stop();
    end
endmodule
